// ===== design/lsp_packer.sv
// lane sample packer: tx mapping into lane words, rx unpacking and check
`timescale 1ns/10ps
`include "lsp_defines.svh"
// Contract
// - one 32-bit word per lane per clock
// - stream port is lanes times 32 bits
// - two 16-bit samples per lane word
// - bits 15:14 control, 13:0 sample value
// - same mapping every lane, no spreading
// - one sample per two-octet frame
// - lane count parameter from 1 to 12
// - 14-bit samples extended by two control bits
// - converter runs at twice clock rate
// - octets per frame fixed at two
// - receive check raises one pass flag
module lsp_packer
#(
   parameter int LANES = `LSP_LANES
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [`LSP_MAX_LANES*14-1:0] tx_early_data,
   input wire logic [`LSP_MAX_LANES*14-1:0] tx_late_data,
   input wire logic [`LSP_MAX_LANES*2-1:0] tx_ctrl,
   input wire logic tx_use_internal,
   input wire logic tx_tready,
   output logic [LANES*32-1:0] tx_tdata,
   input wire logic [LANES*32-1:0] rx_tdata,
   input wire logic rx_tvalid,
   output logic [LANES*14-1:0] rx_early_data,
   output logic [LANES*14-1:0] rx_late_data,
   output logic [LANES*2-1:0] rx_early_ctrl,
   output logic [LANES*2-1:0] rx_late_ctrl,
   output logic rx_data_valid,
   output logic rx_pass
);
   // fixed frame shape; changing octets per frame needs a remap
   localparam int OCTETS = `LSP_OCTETS_PER_FRAME;
   localparam int SAMPLES_PER_WORD = `LSP_WORD_W / (OCTETS * 8);

   // elaboration guards on the configuration
   // an unsupported shape stops elaboration instead of mis-mapping lanes
   if (LANES < 1 || LANES > `LSP_MAX_LANES)
   begin : g_bad_lanes
      $error("lane count out of range");
   end
   if (OCTETS % 2 != 0 || SAMPLES_PER_WORD != 2)
   begin : g_bad_octets
      $error("octets per frame unsupported");
   end

   typedef struct packed
   {
      logic [LANES*32-1:0] tx_word;
      logic [LANES*14-1:0] rx_early;
      logic [LANES*14-1:0] rx_late;
      logic [LANES*2-1:0] rx_ectl;
      logic [LANES*2-1:0] rx_lctl;
      logic rx_valid;
      lsp_pkg::lsp_chk_e chk;
      logic [7:0] good_cnt;
      logic pass;
   } lsp_top_s;

   lsp_top_s st_q;
   lsp_top_s st_d;

   // internal waveform for the self-test path and expected rx values
   logic [LANES*14-1:0] gen_early;  // generator earlier sample
   logic [LANES*14-1:0] gen_late;  // generator later sample
   logic [LANES-1:0] lane_match;  // per-lane compare result

   genvar g;
   for (g = 0; g < LANES; g++)
   begin : g_lane
      lsp_wave_gen u_gen
      (
         .clk(clk),
         .sys_rst(sys_rst),
         .seed(16'(g * 16'h1000)),
         .early_data(gen_early[g*14 +: 14]),
         .late_data(gen_late[g*14 +: 14])
      );
      lsp_lane_check u_chk
      (
         .word(rx_tdata[g*32 +: 32]),
         .exp_early(gen_early[g*14 +: 14]),
         .exp_late(gen_late[g*14 +: 14]),
         .match(lane_match[g])
      );
   end

   // next state: mapping on both directions and the pass tracker
   always_comb
   begin
      lsp_pkg::lsp_data_t e_d;
      lsp_pkg::lsp_data_t l_d;
      lsp_pkg::lsp_ctrl_t c;
      lsp_pkg::lsp_word_t w;
      e_d = '0;
      l_d = '0;
      c = '0;
      w = '0;
      st_d = st_q;
      // tx: hold the word while the core stalls; sample pairs offered during the stall are not captured
      if (tx_tready)
      begin
         for (int i = 0; i < LANES; i++)
         begin
            // each lane only uses its own slice, same mapping
            if (tx_use_internal)
            begin
               e_d = gen_early[i*14 +: 14];
               l_d = gen_late[i*14 +: 14];
               c = `LSP_CTRL_PATTERN;
            end
            else
            begin
               e_d = tx_early_data[i*14 +: 14];
               l_d = tx_late_data[i*14 +: 14];
               c = tx_ctrl[i*2 +: 2];
            end
            // control on top of data, then early low, late high
            w = lsp_pkg::lsp_pack(lsp_pkg::lsp_make_sample(c, e_d),
               lsp_pkg::lsp_make_sample(c, l_d));
            st_d.tx_word[i*32 +: 32] = w;
         end
      end
      // rx: unpack every lane word the same way
      st_d.rx_valid = rx_tvalid;
      if (rx_tvalid)
      begin
         for (int i = 0; i < LANES; i++)
         begin
            w = rx_tdata[i*32 +: 32];
            st_d.rx_early[i*14 +: 14] = w[`LSP_EARLY_LSB +: 14];
            st_d.rx_ectl[i*2 +: 2] = w[`LSP_EARLY_LSB + `LSP_CTRL_LSB +: 2];
            st_d.rx_late[i*14 +: 14] = w[`LSP_LATE_LSB +: 14];
            st_d.rx_lctl[i*2 +: 2] = w[`LSP_LATE_LSB + `LSP_CTRL_LSB +: 2];
         end
      end
      // pass tracker: needs a run of matching words, then latches
      case (st_q.chk)
         lsp_pkg::LSP_ST_IDLE:
         begin
            if (rx_tvalid)
            begin
               st_d.chk = lsp_pkg::LSP_ST_HUNT;
               st_d.good_cnt = '0;
            end
         end
         lsp_pkg::LSP_ST_HUNT:
         begin
            if (rx_tvalid && &lane_match)
            begin
               st_d.good_cnt = 8'(st_q.good_cnt + 8'h01);
               if (st_q.good_cnt == 8'(`LSP_PASS_COUNT - 1))
               begin
                  st_d.chk = lsp_pkg::LSP_ST_PASS;
                  st_d.pass = 1'b1;
               end
            end
            else if (rx_tvalid)
            begin
               // a mismatch restarts the run; alignment may still settle
               st_d.good_cnt = '0;
            end
         end
         lsp_pkg::LSP_ST_PASS:
         begin
            st_d.pass = 1'b1;  // sticky until reset
         end
         default:
         begin
            st_d.chk = lsp_pkg::LSP_ST_IDLE;
         end
      endcase
   end

   // single register stage for all state; sysref is not handled here
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_q <= '0;
         st_q.chk <= lsp_pkg::LSP_ST_IDLE;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // every output straight from the state register
   assign tx_tdata = st_q.tx_word;
   assign rx_early_data = st_q.rx_early;
   assign rx_late_data = st_q.rx_late;
   assign rx_early_ctrl = st_q.rx_ectl;
   assign rx_late_ctrl = st_q.rx_lctl;
   assign rx_data_valid = st_q.rx_valid;
   assign rx_pass = st_q.pass;
endmodule

// ===== design/lsp_defines.svh
// constants for the lane sample packer
`ifndef LSP_DEFINES_SVH
`define LSP_DEFINES_SVH
`define LSP_LANES 2
`define LSP_MAX_LANES 12
`define LSP_WORD_W 32
`define LSP_SAMPLE_W 16
`define LSP_DATA_W 14
`define LSP_CTRL_LSB 14
`define LSP_CTRL_MSB 15
`define LSP_OCTETS_PER_FRAME 2
`define LSP_EARLY_LSB 0
`define LSP_LATE_LSB 16
`define LSP_PHASE_STEP 16'h0400
`define LSP_CTRL_PATTERN 2'h1
`define LSP_PASS_COUNT 8'h20
`endif

// ===== design/lsp_pkg.sv
// types shared by the lane sample packer files
package lsp_pkg;
   typedef logic [13:0] lsp_data_t;
   typedef logic [1:0] lsp_ctrl_t;
   typedef logic [15:0] lsp_sample_t;
   typedef logic [31:0] lsp_word_t;
   typedef enum logic [2:0]
   {
      LSP_ST_IDLE = 3'b001,
      LSP_ST_HUNT = 3'b010,
      LSP_ST_PASS = 3'b100
   } lsp_chk_e;
   // join control and data into one sample
   function automatic lsp_sample_t lsp_make_sample(input lsp_ctrl_t c,
      input lsp_data_t d);
      lsp_make_sample = {c, d};
   endfunction
   // place early sample low, late sample high
   function automatic lsp_word_t lsp_pack(input lsp_sample_t early,
      input lsp_sample_t late);
      lsp_pack = {late, early};
   endfunction
endpackage

// ===== design/lsp_wave_gen.sv
// waveform source: two 14-bit samples per clock, ramp-like sine stand-in
`timescale 1ns/10ps
`include "lsp_defines.svh"
module lsp_wave_gen
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] seed,
   output logic [13:0] early_data,
   output logic [13:0] late_data
);
   typedef struct packed
   {
      logic [15:0] phase;
   } lsp_gen_s;
   lsp_gen_s st_q;
   lsp_gen_s st_d;
   // phase advances by two samples per clock
   always_comb
   begin
      st_d = st_q;
      st_d.phase = 16'(st_q.phase + 16'(`LSP_PHASE_STEP * 2));
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end
   // top bits of phase plus seed, so each lane differs
   assign early_data = 14'((st_q.phase + seed) >> 2);
   assign late_data = 14'((16'(st_q.phase + 16'(`LSP_PHASE_STEP)) + seed)
      >> 2);
endmodule

// ===== design/lsp_lane_check.sv
// per-lane receive check: unpacks a word and compares to expected
`timescale 1ns/10ps
`include "lsp_defines.svh"
module lsp_lane_check
(
   input wire logic [31:0] word,
   input wire logic [13:0] exp_early,
   input wire logic [13:0] exp_late,
   output logic match
);
   logic [15:0] early_s;
   logic [15:0] late_s;
   // earlier sample low half, later high half
   assign early_s = word[`LSP_EARLY_LSB +: `LSP_SAMPLE_W];
   assign late_s = word[`LSP_LATE_LSB +: `LSP_SAMPLE_W];
   // control bits and waveform both must agree
   assign match = (early_s == lsp_pkg::lsp_make_sample(`LSP_CTRL_PATTERN,
      exp_early)) && (late_s == lsp_pkg::lsp_make_sample(`LSP_CTRL_PATTERN,
      exp_late));
endmodule

// ===== sim/lsp_checker.sv
// port timing checker for the lane sample packer
`timescale 1ns/10ps
module lsp_checker
#(
   parameter int LANES = 2
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [167:0] tx_early_data,
   input wire logic [167:0] tx_late_data,
   input wire logic [23:0] tx_ctrl,
   input wire logic tx_use_internal,
   input wire logic tx_tready,
   input wire logic [LANES*32-1:0] tx_tdata,
   input wire logic [LANES*32-1:0] rx_tdata,
   input wire logic rx_tvalid,
   input wire logic [LANES*14-1:0] rx_early_data,
   input wire logic [LANES*14-1:0] rx_late_data,
   input wire logic [LANES*2-1:0] rx_early_ctrl,
   input wire logic [LANES*2-1:0] rx_late_ctrl,
   input wire logic rx_data_valid,
   input wire logic rx_pass
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // external data taken only while the core is ready
   wire logic ext = tx_tready && !tx_use_internal;
   AST_TX_LO: assert property (ext |=> tx_tdata[15:0] ==
      $past({tx_ctrl[1:0], tx_early_data[13:0]})) else $error("tx low");
   AST_TX_HI: assert property (ext |=> tx_tdata[31:16] ==
      $past({tx_ctrl[1:0], tx_late_data[13:0]})) else $error("tx high");
   AST_TX_LN: assert property (ext |=> tx_tdata[LANES*32-1-:16] ==
      $past({tx_ctrl[LANES*2-1-:2], tx_late_data[LANES*14-1-:14]}))
      else $error("tx last lane");
   AST_TX_HOLD: assert property (!tx_tready |=> $stable(tx_tdata))
      else $error("tx not held");
   AST_TX_GEN: assert property (tx_tready && tx_use_internal |=>
      tx_tdata[15:14] == 2'h1 && tx_tdata[31:30] == 2'h1)
      else $error("tx generator ctrl");
   AST_RX_VAL: assert property (1'b1 |=>
      rx_data_valid == $past(rx_tvalid)) else $error("rx valid");
   AST_RX_LO: assert property (rx_tvalid |=>
      {rx_early_ctrl[1:0], rx_early_data[13:0]} == $past(rx_tdata[15:0]))
      else $error("rx low");
   AST_RX_HI: assert property (rx_tvalid |=>
      {rx_late_ctrl[LANES*2-1-:2], rx_late_data[LANES*14-1-:14]} ==
      $past(rx_tdata[LANES*32-1-:16])) else $error("rx last lane");
   AST_RX_HOLD: assert property (!rx_tvalid |=>
      $stable(rx_early_data) && $stable(rx_late_data)) else $error("rx hold");
   AST_PASS: assert property (rx_pass |=> rx_pass)
      else $error("pass dropped");
   // main scenarios reached
   cover property ($rose(rx_pass));
   cover property (!tx_tready ##1 tx_tready);
   cover property (tx_tready && tx_use_internal);
endmodule
bind lsp_packer lsp_checker #(.LANES(LANES)) u_chk (.*);

// ===== sim/lsp_link_model.sv
// link core stream port model: stalls on demand, loops lane words back
`timescale 1ns/10ps
module lsp_link_model
#(
   parameter int LANES = 2
)
(
   input wire logic stall,
   input wire logic [LANES*32-1:0] tx_tdata,
   output logic tx_tready,
   output logic [LANES*32-1:0] rx_tdata,
   output logic rx_tvalid
);
   // one word per lane per cycle, stalls refuse words
   // only the stream clock exists here; a sysref would follow it
   assign tx_tready = !stall;
   assign rx_tvalid = !stall;
   // an idle port shows inverted data so stale words cannot match
   assign rx_tdata = stall ? ~tx_tdata : tx_tdata;
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the lane sample packer
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
   $display("MISMATCH %0t compare", $time); end end
module tb_top;
   logic clk = 0, sys_rst = 1, tx_use_internal = 0, stall = 0;
   logic [167:0] tx_early_data = 0, tx_late_data = 0;
   logic [23:0] tx_ctrl = 0;
   logic [63:0] tx_tdata, rx_tdata, w;
   logic tx_tready, rx_tvalid, rx_data_valid, rx_pass;
   logic [27:0] rx_early_data, rx_late_data;
   logic [3:0] rx_early_ctrl, rx_late_ctrl;
   logic [15:0] ph, q;
   int err_count = 0, tests_run = 0, cyc = 0;
   lsp_packer #(.LANES(2)) dut (.*);
   lsp_link_model #(.LANES(2)) link (.*);
   initial forever #20 clk = ~clk;
   // generator phase as the rx check counts it
   always @(posedge clk) ph <= sys_rst ? 16'h0 : ph + 16'h0800;
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         err_count++;
         end_sim;
      end
   end
   task end_sim;
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // distinct samples per lane, word then loop-back unpacking
   task t_map;
      tx_early_data[27:0] = {14'h1234, 14'h2A5A};
      tx_late_data[27:0] = {14'h0F0F, 14'h15A5};
      tx_ctrl[3:0] = {2'h3, 2'h2};
      @(negedge clk);
      w = {2'h3, 14'h0F0F, 2'h3, 14'h1234, 2'h2, 14'h15A5, 2'h2, 14'h2A5A};
      `CHK(tx_tdata, w)
      @(negedge clk);
      `CHK({rx_early_ctrl, rx_early_data}, {4'hE, 28'h48D2A5A})
      `CHK({rx_late_ctrl, rx_late_data, rx_data_valid},
         {4'hE, 28'h3C3D5A5, 1'b1})
   endtask
   // stalled core holds words; generator then feeds the word
   task t_stall;
      stall = 1;
      tx_early_data[13:0] = 14'h0001;
      repeat (2) @(negedge clk);
      `CHK(tx_tdata, w)
      `CHK({rx_data_valid, rx_late_data}, {1'b0, 28'h3C3D5A5})
      stall = 0;
      tx_use_internal = 1;
      q = ph;
      @(negedge clk);
      `CHK(tx_tdata[15:0], {2'h1, 14'(q >> 2)})
      q = q + 16'h1400;
      `CHK(tx_tdata[63:48], {2'h1, 14'(q >> 2)})
      tx_use_internal = 0;
   endtask
   // expected waveform looped back until the pass flag latches
   task t_pass;
      for (int i = 0; i < 40; i++)
      begin
         if (i == 20)
            `CHK(rx_pass, 1'b0)
         for (int g = 0; g < 2; g++)
         begin
            q = ph + 16'h0800 + 16'(g) * 16'h1000;
            tx_early_data[g*14+:14] = 14'(q >> 2);
            tx_late_data[g*14+:14] = 14'((q + 16'h0400) >> 2);
            tx_ctrl[g*2+:2] = 2'h1;
         end
         @(negedge clk);
      end
      `CHK(rx_pass, 1'b1)
      tx_ctrl[1:0] = 2'h0;
      repeat (3) @(negedge clk);
      `CHK(rx_pass, 1'b1)
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      sys_rst = 0;
      t_map;
      t_stall;
      t_pass;
      end_sim;
   end
endmodule
